// ### hw/spr_cfg.svh
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH

// bus widths of the scratchpad link
`define SPR_TAG_IDX_W   16
`define SPR_DATA_IDX_W  18
`define SPR_PA_W        24
`define SPR_DATA_W      32
`define SPR_MASK_W      4
`define SPR_TAG_RD_W    24

// reset values
`define SPR_STB_IDLE    4'h0
`define SPR_FLAG_RST    1'b0
`define SPR_TAG_IDX_RST 16'h0000
`define SPR_DATA_IDX_RST 18'h00000
`define SPR_PA_RST      24'h000000
`define SPR_DATA_RST    32'h00000000
`define SPR_MASK_RST    4'h0

`endif

// ### hw/spr_pkg.sv
`include "spr_cfg.svh"

package spr_pkg;

  // access kinds offered by the pipeline
  typedef enum logic [4:0] {
    SPR_OP_LOAD    = 5'h01,
    SPR_OP_STORE   = 5'h02,
    SPR_OP_TAG_RD  = 5'h04,
    SPR_OP_TAG_WR  = 5'h08,
    SPR_OP_DATA_WR = 5'h10
  } spr_op_e;

  // lock sequence states
  typedef enum logic [2:0] {
    SPR_LK_IDLE  = 3'h1,
    SPR_LK_ARMED = 3'h2,
    SPR_LK_HELD  = 3'h4
  } spr_lock_e;

  // the four strobes of the data-side port
  typedef struct packed {
    logic data_write_strobe;
    logic tag_write_strobe;
    logic tag_read_strobe;
    logic data_read_strobe;
  } spr_strobe_s;

  // one request from the pipeline
  typedef struct packed {
    spr_op_e                     op;
    logic                        lock;
    logic [`SPR_TAG_IDX_W-1:0]   tag_idx;
    logic [`SPR_DATA_IDX_W-1:0]  data_idx;
    logic [`SPR_PA_W-1:0]        pa;
    logic [`SPR_DATA_W-1:0]      wdata;
    logic [`SPR_MASK_W-1:0]      mask;
  } spr_req_s;

  // contents of the data port for a write
  typedef struct packed {
    logic [`SPR_DATA_IDX_W-1:0]  idx;
    logic [`SPR_DATA_W-1:0]      data;
    logic [`SPR_MASK_W-1:0]      mask;
  } spr_wr_s;

  // completion of one request
  typedef struct packed {
    logic                        hit;
    logic [`SPR_DATA_W-1:0]      rdata;
    logic [`SPR_TAG_RD_W-1:0]    tag_rdata;
  } spr_rsp_s;

endpackage

// ### hw/spr_store_buf.sv
`timescale 1ns/10ps
`include "spr_cfg.svh"

// single-entry buffer for store data that has passed its lookup
module spr_store_buf (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  // fill side
  input  wire logic              i_load,
  input  wire spr_pkg::spr_wr_s  i_entry,
  // drain side
  input  wire logic              i_take,
  output logic                   o_full,
  output spr_pkg::spr_wr_s       o_entry
);
  import spr_pkg::*;

  logic     full_r;
  logic     full_nxt;
  spr_wr_s  entry_r;
  spr_wr_s  entry_nxt;

  // a fill in the drain cycle keeps the entry occupied
  always_comb begin
    full_nxt  = full_r;
    entry_nxt = entry_r;
    if (i_take) begin
      full_nxt = 1'b0;
    end
    if (i_load) begin
      full_nxt  = 1'b1;
      entry_nxt = i_entry;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      full_r  <= `SPR_FLAG_RST;
      entry_r <= '0;
    end else begin
      full_r  <= full_nxt;
      entry_r <= entry_nxt;
    end
  end

  assign o_full  = full_r;
  assign o_entry = entry_r;

endmodule

// ### hw/spr_port.sv
`timescale 1ns/10ps
`include "spr_cfg.svh"

module spr_port (
  // clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_reset,
  // requests from the pipeline
  input  wire logic                         i_req_valid,
  input  wire spr_pkg::spr_req_s            i_req,
  output logic                              o_req_ready,
  // completions to the pipeline
  output logic                              o_rsp_valid,
  output spr_pkg::spr_rsp_s                 o_rsp,
  // scratchpad link, outputs
  output spr_pkg::spr_strobe_s              o_strobe,
  output logic [`SPR_TAG_IDX_W-1:0]         o_dside_tag_index,
  output logic [`SPR_DATA_IDX_W-1:0]        o_dside_data_index,
  output logic [`SPR_PA_W-1:0]              o_dside_compare_phys_addr,
  output logic [`SPR_DATA_W-1:0]            o_dside_write_data,
  output logic [`SPR_MASK_W-1:0]            o_dside_byte_mask,
  output logic [`SPR_TAG_RD_W-1:0]          o_tag_write_data,
  output logic                              o_lock,
  // scratchpad link, inputs
  input  wire logic                         i_hit,
  input  wire logic                         i_stall,
  input  wire logic [`SPR_DATA_W-1:0]       i_dside_read_data,
  input  wire logic [`SPR_TAG_RD_W-1:0]     i_dside_tag_read_data
);
  import spr_pkg::*;

  // presenting stage: strobes and indices of the current cycle
  logic         a_valid_r;
  logic         a_valid_nxt;
  spr_strobe_s  a_stb_r;
  spr_strobe_s  a_stb_nxt;
  spr_req_s     a_req_r;
  spr_req_s     a_req_nxt;
  spr_wr_s      a_wr_r;
  spr_wr_s      a_wr_nxt;
  // answering stage: compare address and hit/stall
  logic         b_valid_r;
  logic         b_valid_nxt;
  spr_strobe_s  b_stb_r;
  spr_strobe_s  b_stb_nxt;
  spr_req_s     b_req_r;
  spr_req_s     b_req_nxt;
  spr_wr_s      b_wr_r;
  spr_wr_s      b_wr_nxt;
  // completion registers
  logic         rsp_valid_r;
  logic         rsp_valid_nxt;
  spr_rsp_s     rsp_r;
  spr_rsp_s     rsp_nxt;
  // lock sequence
  spr_lock_e    lock_r;
  spr_lock_e    lock_nxt;
  // helpers
  logic         a_advance;
  logic         issue;
  logic         b_done;
  logic         pend_store;
  logic         accept;
  logic         buf_full;
  logic         buf_take;
  logic         buf_load;
  logic         lock_miss;
  spr_wr_s      buf_entry;
  spr_wr_s      hit_entry;

  // buffered store data waiting for a free data port
  spr_store_buf u_buf (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_load     (buf_load),
    .i_entry    (hit_entry),
    .i_take     (buf_take),
    .o_full     (buf_full),
    .o_entry    (buf_entry)
  );

  // stage handshakes; stall concerns the answering stage
  assign b_done    = b_valid_r & ~i_stall;
  assign issue     = a_valid_r & ~i_stall;
  assign a_advance = ~a_valid_r | ~i_stall;
  assign pend_store = (a_valid_r & (a_req_r.op == SPR_OP_STORE)) |
                      (b_valid_r & (b_req_r.op == SPR_OP_STORE));
  assign hit_entry = '{idx: b_req_r.data_idx, data: b_req_r.wdata,
                       mask: b_req_r.mask};
  // a store that hits parks its data in the buffer
  assign buf_load  = b_done & i_hit & (b_req_r.op == SPR_OP_STORE);
  assign lock_miss = b_done & ~i_hit & b_req_r.lock &
                     (b_req_r.op == SPR_OP_LOAD);

  // choose what the presenting stage holds next
  always_comb begin
    accept    = 1'b0;
    buf_take  = 1'b0;
    a_valid_nxt = a_valid_r;
    a_stb_nxt   = a_stb_r;
    a_req_nxt   = a_req_r;
    a_wr_nxt    = a_wr_r;
    if (a_advance) begin
      a_valid_nxt = 1'b0;
      a_stb_nxt   = `SPR_STB_IDLE;
      a_req_nxt   = i_req;
      a_wr_nxt    = buf_entry;
      if (i_req_valid) begin
        unique case (i_req.op)
          SPR_OP_LOAD, SPR_OP_TAG_RD: begin
            accept = 1'b1;
            a_stb_nxt = '{data_write_strobe: 1'b0, tag_write_strobe: 1'b0,
                          tag_read_strobe: 1'b1, data_read_strobe: 1'b1};
          end
          SPR_OP_STORE: begin
            accept   = ~pend_store;
            buf_take = ~pend_store & buf_full;
            a_stb_nxt = '{data_write_strobe: buf_full, tag_write_strobe: 1'b0,
                          tag_read_strobe: 1'b1, data_read_strobe: 1'b0};
          end
          SPR_OP_TAG_WR: begin
            accept = ~buf_full;
            a_stb_nxt = '{data_write_strobe: 1'b0, tag_write_strobe: 1'b1,
                          tag_read_strobe: 1'b0, data_read_strobe: 1'b0};
          end
          default: begin
            accept = ~buf_full;
            a_wr_nxt = '{idx: i_req.data_idx, data: i_req.wdata,
                         mask: i_req.mask};
            a_stb_nxt = '{data_write_strobe: 1'b1, tag_write_strobe: 1'b0,
                          tag_read_strobe: 1'b0, data_read_strobe: 1'b0};
          end
        endcase
      end
      a_valid_nxt = accept;
      // older store data goes out when nothing else could be taken
      if (!accept && buf_full) begin
        buf_take    = 1'b1;
        a_valid_nxt = 1'b1;
        a_req_nxt.op   = SPR_OP_DATA_WR;
        a_req_nxt.lock = 1'b0;
        a_stb_nxt = '{data_write_strobe: 1'b1, tag_write_strobe: 1'b0,
                      tag_read_strobe: 1'b0, data_read_strobe: 1'b0};
      end
      if (!a_valid_nxt) begin
        a_stb_nxt = `SPR_STB_IDLE;
      end
    end
  end

  // answering stage takes the presenting stage once stall is low
  always_comb begin
    b_valid_nxt = b_valid_r;
    b_stb_nxt   = b_stb_r;
    b_req_nxt   = b_req_r;
    b_wr_nxt    = b_wr_r;
    if (!i_stall) begin
      b_valid_nxt = a_valid_r;
      b_stb_nxt   = a_stb_r;
      if (a_valid_r) begin
        b_req_nxt = a_req_r;
        b_wr_nxt  = a_wr_r;
      end
    end
  end

  // completion: hit only counts with stall low
  always_comb begin
    rsp_valid_nxt = b_done;
    rsp_nxt       = rsp_r;
    if (b_done) begin
      rsp_nxt.hit       = i_hit;
      rsp_nxt.rdata     = i_dside_read_data;
      rsp_nxt.tag_rdata = i_dside_tag_read_data;
    end
  end

  // lock sequence for atomic read-modify-write
  always_comb begin
    lock_nxt = lock_r;
    unique case (lock_r)
      SPR_LK_IDLE: begin
        if (a_advance && accept && i_req.lock &&
            (i_req.op == SPR_OP_LOAD)) begin
          lock_nxt = SPR_LK_ARMED;
        end
      end
      SPR_LK_ARMED: begin
        if (issue) begin
          lock_nxt = SPR_LK_HELD;
        end
      end
      default: begin
        if (lock_miss) begin
          lock_nxt = SPR_LK_IDLE;
        end else if (issue && a_req_r.lock &&
                     (a_req_r.op == SPR_OP_DATA_WR)) begin
          lock_nxt = SPR_LK_IDLE;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      a_valid_r   <= `SPR_FLAG_RST;
      a_stb_r     <= `SPR_STB_IDLE;
      a_req_r     <= '0;
      a_wr_r      <= '0;
      b_valid_r   <= `SPR_FLAG_RST;
      b_stb_r     <= `SPR_STB_IDLE;
      b_req_r     <= '0;
      b_wr_r      <= '0;
      rsp_valid_r <= `SPR_FLAG_RST;
      rsp_r       <= '0;
      lock_r      <= SPR_LK_IDLE;
    end else begin
      a_valid_r   <= a_valid_nxt;
      a_stb_r     <= a_stb_nxt;
      a_req_r     <= a_req_nxt;
      a_wr_r      <= a_wr_nxt;
      b_valid_r   <= b_valid_nxt;
      b_stb_r     <= b_stb_nxt;
      b_req_r     <= b_req_nxt;
      b_wr_r      <= b_wr_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r       <= rsp_nxt;
      lock_r      <= lock_nxt;
    end
  end

  // link outputs: strobes gated by stall, pending indices held
  always_comb begin
    o_strobe = issue ? a_stb_r : spr_strobe_s'(`SPR_STB_IDLE);
    o_dside_tag_index  = i_stall ? b_req_r.tag_idx : a_req_r.tag_idx;
    o_dside_data_index = i_stall ? b_wr_r.idx : a_wr_r.idx;
    o_dside_write_data = i_stall ? b_wr_r.data : a_wr_r.data;
    o_dside_byte_mask  = i_stall ? b_wr_r.mask : a_wr_r.mask;
    if (i_stall && !b_stb_r.data_write_strobe) begin
      o_dside_data_index = b_req_r.data_idx;
    end
    if (!i_stall && a_stb_r.data_read_strobe) begin
      o_dside_data_index = a_req_r.data_idx;
    end
    o_lock = (lock_r == SPR_LK_HELD) & ~lock_miss |
             (lock_r == SPR_LK_ARMED) & issue;
  end

  assign o_dside_compare_phys_addr = b_req_r.pa;
  assign o_tag_write_data = i_stall ? b_req_r.wdata[`SPR_TAG_RD_W-1:0]
                                    : a_req_r.wdata[`SPR_TAG_RD_W-1:0];
  assign o_req_ready = a_advance & accept;
  assign o_rsp_valid = rsp_valid_r;
  assign o_rsp       = rsp_r;

  // tag read strobe followed by stall
  sequence s_read_stalled;
    (o_strobe.tag_read_strobe && !i_stall) ##1 i_stall;
  endsequence

  sequence s_write_stalled;
    (o_strobe.data_write_strobe && !i_stall) ##1 i_stall;
  endsequence

  a_stall_no_strobe: assert property (@(posedge i_core_clk)
    disable iff (i_reset) i_stall |-> (o_strobe == `SPR_STB_IDLE))
    else $error("strobe driven during stall");

  a_strobe_legal: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    !(o_strobe.data_read_strobe && !o_strobe.tag_read_strobe) &&
    !(o_strobe.tag_write_strobe &&
      (o_strobe.tag_read_strobe || o_strobe.data_read_strobe)) &&
    !(o_strobe.tag_write_strobe && o_strobe.data_write_strobe) &&
    !(o_strobe.data_write_strobe && o_strobe.data_read_strobe))
    else $error("illegal strobe combination");

  a_tag_idx_hold: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    s_read_stalled |-> $stable(o_dside_tag_index))
    else $error("tag index moved during stall");

  a_wr_hold: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    s_write_stalled |-> $stable(o_dside_write_data) &&
                        $stable(o_dside_byte_mask))
    else $error("write data moved during stall");

  a_cmp_next: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (o_strobe.tag_read_strobe && !i_stall) |=>
      o_dside_compare_phys_addr == $past(a_req_r.pa))
    else $error("compare address not in following cycle");

  a_rsp_hit: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (b_valid_r && !i_stall) |=> o_rsp_valid && o_rsp.hit == $past(i_hit))
    else $error("completion does not carry hit");

  a_rsp_stall: assert property (@(posedge i_core_clk)
    disable iff (i_reset) i_stall |=> !o_rsp_valid)
    else $error("completion taken during stall");

  a_lock_miss: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (lock_r == SPR_LK_HELD && b_valid_r && b_req_r.lock &&
     b_req_r.op == SPR_OP_LOAD && !i_stall && !i_hit) |-> !o_lock ##1 !o_lock)
    else $error("lock kept after missed read");

  a_lock_rise: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    $rose(o_lock) |-> o_strobe.tag_read_strobe && o_strobe.data_read_strobe)
    else $error("lock rose without read strobes");

endmodule

// ### test/spr_ram_model.sv
`timescale 1ns/10ps
`include "spr_cfg.svh"

// behavioural scratchpad array answering the port one cycle after a strobe
module spr_ram_model #(
  parameter logic [7:0] BASE = 8'h40
) (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  // link from the port
  input  wire spr_pkg::spr_strobe_s     i_strobe,
  input  wire logic [`SPR_DATA_IDX_W-1:0] i_data_index,
  input  wire logic [`SPR_PA_W-1:0]     i_pa,
  input  wire logic [`SPR_DATA_W-1:0]   i_wdata,
  input  wire logic [`SPR_MASK_W-1:0]   i_mask,
  input  wire logic [`SPR_TAG_RD_W-1:0] i_tag_wdata,
  // stall length asked by the bench
  input  wire logic [3:0]               i_stall_cycles,
  // answers to the port
  output logic                          o_hit,
  output logic                          o_stall,
  output logic [`SPR_DATA_W-1:0]        o_rdata,
  output logic [`SPR_TAG_RD_W-1:0]      o_tag_rdata
);
  import spr_pkg::*;
  logic [`SPR_DATA_W-1:0]   mem [16];
  logic [`SPR_TAG_RD_W-1:0] tag_r;
  spr_strobe_s              stb_r;
  logic [3:0]               idx_r;
  logic [`SPR_DATA_W-1:0]   wd_r;
  logic [`SPR_MASK_W-1:0]   mk_r;
  logic [`SPR_TAG_RD_W-1:0] twd_r;
  logic [3:0]               cnt_r;
  logic                     pend;

  // one stall line covers tag and data halves together
  assign pend    = |stb_r;
  assign o_stall = pend && (cnt_r != 4'h0);
  // hit from the compare address, inverted while stalled
  assign o_hit   = pend && ((i_pa[23:16] == BASE) ^ o_stall);
  // unread data bus shows the inverse, never a stale match
  assign o_rdata = (stb_r.data_read_strobe && !o_stall) ? mem[idx_r]
                                                        : ~mem[idx_r];
  assign o_tag_rdata = stb_r.tag_read_strobe ? tag_r : ~tag_r;

  // capture a request, count stalls, then complete it
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      stb_r <= '0;
      cnt_r <= 4'h0;
      tag_r <= '0;
      for (int i = 0; i < 16; i++) mem[i] <= '0;
    end else if (o_stall) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      // lanes by mask, empty mask writes nothing, lock ignored
      if (stb_r.data_write_strobe) begin
        for (int b = 0; b < 4; b++)
          if (mk_r[b]) mem[idx_r][8*b +: 8] <= wd_r[8*b +: 8];
      end
      if (stb_r.tag_write_strobe) tag_r <= twd_r;
      stb_r <= i_strobe;
      idx_r <= i_data_index[3:0];
      wd_r  <= i_wdata;
      mk_r  <= i_mask;
      twd_r <= i_tag_wdata;
      cnt_r <= i_stall_cycles;
    end
  end
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
`include "spr_cfg.svh"

module testbench;
  import spr_pkg::*;
  logic                     i_core_clk;
  logic                     i_reset;
  logic                     valid;
  spr_req_s                 req;
  logic                     ready;
  logic                     rsp_valid;
  spr_rsp_s                 rsp;
  spr_strobe_s              stb;
  logic [`SPR_DATA_IDX_W-1:0] didx;
  logic [`SPR_TAG_IDX_W-1:0] tidx;
  logic [`SPR_TAG_IDX_W-1:0] last_tidx;
  logic [`SPR_PA_W-1:0]     pa;
  logic [`SPR_DATA_W-1:0]   wd;
  logic [`SPR_MASK_W-1:0]   mk;
  logic [`SPR_TAG_RD_W-1:0] twd;
  logic                     lock;
  logic                     hit;
  logic                     stall;
  logic [`SPR_DATA_W-1:0]   rd;
  logic [`SPR_TAG_RD_W-1:0] trd;
  logic [3:0]               stall_cycles;
  logic                     saw_comb;
  spr_rsp_s                 rq[$];
  int                       miscompares;
  int                       cmp_count;
  localparam logic [23:0]   PA_HIT = 24'h400000;

  spr_port i_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_req_valid(valid),
    .i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_valid),
    .o_rsp(rsp), .o_strobe(stb), .o_dside_tag_index(tidx),
    .o_dside_data_index(didx), .o_dside_compare_phys_addr(pa),
    .o_dside_write_data(wd), .o_dside_byte_mask(mk),
    .o_tag_write_data(twd), .o_lock(lock), .i_hit(hit),
    .i_stall(stall), .i_dside_read_data(rd), .i_dside_tag_read_data(trd));

  spr_ram_model i_ram (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_strobe(stb),
    .i_data_index(didx), .i_pa(pa), .i_wdata(wd), .i_mask(mk),
    .i_tag_wdata(twd), .i_stall_cycles(stall_cycles), .o_hit(hit),
    .o_stall(stall), .o_rdata(rd), .o_tag_rdata(trd));

  // clock generation
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // collect completions, flag combined cycles and impossible strobes
  always @(posedge i_core_clk) begin
    if (rsp_valid === 1'b1) rq.push_back(rsp);
    if (stb.data_write_strobe && stb.tag_read_strobe) saw_comb = 1'b1;
    if (stb.tag_read_strobe) last_tidx = tidx;
    if ((stb.data_read_strobe && !stb.tag_read_strobe) ||
        (stb.tag_write_strobe && (stb.tag_read_strobe ||
         stb.data_read_strobe || stb.data_write_strobe)) ||
        (stb.data_write_strobe && stb.data_read_strobe)) begin
      $display("unexpected strobes at %0t: %h vs %h", $time, stb, 4'h0);
      miscompares++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected value at %0t: %h vs %h", $time, got, exp);
      miscompares++;
    end
  endtask

  function automatic spr_req_s mk_req(input spr_op_e op, input logic lk,
      input logic [3:0] idx, input logic [23:0] a,
      input logic [31:0] d, input logic [3:0] m);
    return '{op: op, lock: lk, tag_idx: {12'h000, idx},
             data_idx: {14'h0000, idx}, pa: a, wdata: d, mask: m};
  endfunction

  // offer one request and hold it until taken
  task automatic issue(input spr_req_s r);
    @(posedge i_core_clk);
    valid <= 1'b1;
    req   <= r;
    for (int n = 0; n < 60; n++) begin
      @(negedge i_core_clk);
      if (ready === 1'b1) break;
    end
    @(posedge i_core_clk);
    valid <= 1'b0;
  endtask

  task automatic get_rsp(output spr_rsp_s r);
    for (int n = 0; n < 60 && rq.size() == 0; n++) @(posedge i_core_clk);
    if (rq.size() == 0) begin
      $display("unexpected missing completion at %0t: %h vs %h",
               $time, 1'b0, 1'b1);
      miscompares++;
      r = '0;
    end else r = rq.pop_front();
  endtask

  task automatic settle();
    repeat (12) @(posedge i_core_clk);
    rq.delete();
  endtask

  task automatic load_chk(input logic [3:0] idx, input logic [31:0] exp);
    spr_rsp_s r;
    issue(mk_req(SPR_OP_LOAD, 1'b0, idx, PA_HIT, '0, '0));
    get_rsp(r);
    chk({31'h0, r.hit}, 32'h1);
    chk(r.rdata, exp);
  endtask

  task automatic t_store_load();
    spr_rsp_s r;
    issue(mk_req(SPR_OP_STORE, 1'b0, 4'h3, PA_HIT, 32'h11223344, 4'h5));
    get_rsp(r);
    chk({31'h0, r.hit}, 32'h1);
    settle();
    load_chk(4'h3, 32'h00220044);
  endtask

  task automatic t_stall_load();
    stall_cycles <= 4'h2;
    load_chk(4'h3, 32'h00220044);
    stall_cycles <= 4'h0;
    settle();
  endtask

  task automatic t_miss();
    spr_rsp_s r;
    issue(mk_req(SPR_OP_LOAD, 1'b0, 4'h3, 24'h000000, '0, '0));
    get_rsp(r);
    chk({31'h0, r.hit}, 32'h0);
    settle();
  endtask

  task automatic t_back2back();
    saw_comb = 1'b0;
    issue(mk_req(SPR_OP_STORE, 1'b0, 4'h5, PA_HIT, 32'ha5a5a5a5, 4'hf));
    issue(mk_req(SPR_OP_STORE, 1'b0, 4'h6, PA_HIT, 32'h5a5a5a5a, 4'hf));
    issue(mk_req(SPR_OP_STORE, 1'b0, 4'h5, PA_HIT, 32'hffffffff, 4'h0));
    settle();
    chk({31'h0, saw_comb}, 32'h1);
    load_chk(4'h5, 32'ha5a5a5a5);
    load_chk(4'h6, 32'h5a5a5a5a);
    settle();
  endtask

  task automatic t_tag();
    spr_rsp_s r;
    issue(mk_req(SPR_OP_TAG_WR, 1'b0, 4'h1, PA_HIT, 32'h00abcdef, '0));
    settle();
    issue(mk_req(SPR_OP_TAG_RD, 1'b0, 4'h1, PA_HIT, '0, '0));
    get_rsp(r);
    chk({8'h00, r.tag_rdata}, 32'h00abcdef);
    chk({16'h0000, last_tidx}, 32'h00000001);
    settle();
  endtask

  task automatic t_lock();
    spr_rsp_s r;
    issue(mk_req(SPR_OP_LOAD, 1'b1, 4'h3, 24'h000000, '0, '0));
    get_rsp(r);
    chk({31'h0, lock}, 32'h0);
    settle();
    issue(mk_req(SPR_OP_LOAD, 1'b1, 4'h3, PA_HIT, '0, '0));
    get_rsp(r);
    chk({31'h0, lock}, 32'h1);
    issue(mk_req(SPR_OP_DATA_WR, 1'b1, 4'h7, PA_HIT, 32'hcafe0001, 4'hf));
    settle();
    chk({31'h0, lock}, 32'h0);
    load_chk(4'h7, 32'hcafe0001);
  endtask

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog
  initial begin
    #(25 * 20000);
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    miscompares  = 0;
    cmp_count    = 0;
    saw_comb     = 1'b0;
    last_tidx    = '0;
    valid        = 1'b0;
    req          = '0;
    stall_cycles = 4'h0;
    i_reset      = 1'b1;
    repeat (20) @(posedge i_core_clk);
    chk({27'h0, stb, lock}, 32'h0);
    i_reset <= 1'b0;
    t_store_load();
    t_stall_load();
    t_miss();
    t_back2back();
    t_tag();
    t_lock();
    stop_test();
  end
endmodule
